/* File: verilog/cal_trim_map.svh */
`ifndef CAL_TRIM_MAP_SVH
`define CAL_TRIM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CAL_EN_OFS 12'h070
`define CAL_PORT_OFS 12'h071
`define CAL_STATUS_OFS 12'h072
`define GAIN_A_OFS 12'h07a
`define GAIN_B_OFS 12'h07b
`define REF_ADJ_OFS 12'h07c
`define TERM_A_OFS 12'h07e
`define TERM_B_OFS 12'h07f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAL_EN_BIT 0
`define STAT_VALID_BIT 0
`define STAT_HALTED_BIT 1
`define STAT_ENABLE_BIT 2

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CAL_EN_RST 8'h00
`define TRIM_RST 8'h00
`define REF_ADJ_RST 4'h0
`define CAL_PORT_RST 8'h00
`define CAL_VEC_LEN 673

`endif

/* File: verilog/cal_trim_pkg.sv */
package cal_trim_pkg;

   typedef logic [11:0] reg_addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [9:0] vec_idx_t;

   // Register port request
   typedef struct packed {
      reg_addr_t addr;
      byte_t wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   // Trim values as presented to the analog side
   typedef struct packed {
      byte_t gain_a;
      byte_t gain_b;
      logic [3:0] ref_adj;
      byte_t term_a;
      byte_t term_b;
   } trim_set_s;

   // State held directly in the top module; trims and vector bytes live in its submodules
   typedef struct packed {
      byte_t rdata;
      byte_t cal_en;
      vec_idx_t idx;
      logic valid;
      logic fuse_done;
   } top_state_s;

endpackage

/* File: verilog/trim_reg.sv */
`timescale 1ns/100ps
`default_nettype none

module trim_reg #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Factory load
   input wire logic load_in,
   input wire logic [WIDTH-1:0] load_value_in,
   // Host write
   input wire logic we_in,
   input wire logic [WIDTH-1:0] wdata_in,
   // Trim value
   output logic [WIDTH-1:0] value_out
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // Factory load only happens once after reset, so it may win over a write
   always_comb begin
      state_next = state_reg;
      if (load_in) begin
         state_next.value = load_value_in;
      end else if (we_in) begin
         state_next.value = wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg.value <= RESET_VALUE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign value_out = state_reg.value;

endmodule // trim_reg

`default_nettype wire

/* File: verilog/cal_vector_store.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cal_trim_map.svh"

module cal_vector_store
   import cal_trim_pkg::*;
#(
   parameter int DEPTH = `CAL_VEC_LEN
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Host side
   input wire logic host_we_in,
   input wire vec_idx_t host_idx_in,
   input wire byte_t host_wdata_in,
   output byte_t host_rdata_out,
   // Calibration engine side
   input wire vec_idx_t eng_idx_in,
   output byte_t eng_data_out
);

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      byte_t eng_data;
   } state_s;

   state_s state_reg;
   state_s state_next;

   always_comb begin
      state_next = state_reg;
      if (host_we_in && (int'(host_idx_in) < DEPTH)) begin
         state_next.mem[host_idx_in] = host_wdata_in; // R03
      end
      state_next.eng_data = (int'(eng_idx_in) < DEPTH) ? state_reg.mem[eng_idx_in] : `CAL_PORT_RST;
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign host_rdata_out = (int'(host_idx_in) < DEPTH) ? state_reg.mem[host_idx_in] : `CAL_PORT_RST;
   assign eng_data_out = state_reg.eng_data;

   property p_store_write;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      host_we_in |=> state_reg.mem[$past(host_idx_in)] == $past(host_wdata_in);
   endproperty
   a_store_write: assert property (p_store_write) else $error("vector byte not stored"); // R03

endmodule // cal_vector_store

`default_nettype wire

/* File: verilog/cal_vector_and_trim_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cal_trim_map.svh"

// How it works
// R01 - With the port enabled, each read of the vector port returns the next stored byte in order.
// R02 - A full readout is exactly 673 consecutive port reads, after which the index wraps.
// R03 - Successive port writes load the incoming bytes in order as the calibration values.
// R04 - The host restores calibration by writing 673 previously saved bytes.
// R05 - The host may stream with address hold set so every byte hits the vector port. The code has no address hold; each access carries 0x71.
// R06 - The host must not touch the vector port while calibration is not halted.
// R07 - A sequence that ends before 673 accesses leaves the vector marked invalid.
// R08 - Gain trim A is an 8-bit readable, writable register preset from the factory trim.
// R09 - Gain trim B is an 8-bit readable, writable register preset from the factory trim.
// R10 - Reference trim is a 4-bit field in bits 3:0 preset from factory, bits 7:4 reserved.
// R11 - Termination trim A is an 8-bit readable, writable register preset from factory.
// R12 - Termination trim B is an 8-bit readable, writable register preset from factory.
// R13 - Bit 0 at 0x70 enables the vector port; without it port accesses are ignored.
// R14 - A byte index is cleared when the enable is set and steps once per port access.
module cal_vector_and_trim_regs
   import cal_trim_pkg::*;
#(
   parameter int VEC_LEN = `CAL_VEC_LEN
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Register port
   input wire bus_req_s reg_bus_in,
   output byte_t rdata_out,
   // Factory trim values
   input wire trim_set_s fuse_trims_in,
   // Calibration engine
   input wire logic calibration_halted_in,
   input wire vec_idx_t eng_idx_in,
   output byte_t eng_data_out,
   output logic cal_port_enable_out,
   output logic vector_valid_out,
   // Trim outputs
   output wire trim_set_s trims_out
);

   localparam vec_idx_t LAST_IDX = vec_idx_t'(VEC_LEN - 1);

   // ----------------------------------------
   // State
   // ----------------------------------------
   top_state_s state_reg;
   top_state_s state_next;

   logic port_hit;
   logic port_ok;
   logic port_bad;
   logic en_write;
   logic en_rise;
   logic en_fall;
   logic fuse_load;
   byte_t host_rdata;
   byte_t status_byte;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   always_comb begin
      port_hit = (reg_bus_in.rd || reg_bus_in.wr) && (reg_bus_in.addr == `CAL_PORT_OFS);
      // Port is dead unless enabled; halted check guards the stored vector
      port_ok = port_hit && state_reg.cal_en[`CAL_EN_BIT] && calibration_halted_in; // R13
      port_bad = port_hit && state_reg.cal_en[`CAL_EN_BIT] && !calibration_halted_in;
      en_write = reg_bus_in.wr && (reg_bus_in.addr == `CAL_EN_OFS);
      en_rise = en_write && !state_reg.cal_en[`CAL_EN_BIT] && reg_bus_in.wdata[`CAL_EN_BIT];
      en_fall = en_write && state_reg.cal_en[`CAL_EN_BIT] && !reg_bus_in.wdata[`CAL_EN_BIT];
      fuse_load = !state_reg.fuse_done;
      status_byte = '0;
      status_byte[`STAT_VALID_BIT] = state_reg.valid;
      status_byte[`STAT_HALTED_BIT] = calibration_halted_in;
      status_byte[`STAT_ENABLE_BIT] = state_reg.cal_en[`CAL_EN_BIT];
   end

   // ----------------------------------------
   // Vector storage
   // ----------------------------------------
   cal_vector_store #(
      .DEPTH(VEC_LEN)
   ) u_store (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .host_we_in(port_ok && reg_bus_in.wr), // R03
      .host_idx_in(state_reg.idx),
      .host_wdata_in(reg_bus_in.wdata),
      .host_rdata_out(host_rdata),
      .eng_idx_in(eng_idx_in),
      .eng_data_out(eng_data_out)
   );

   // ----------------------------------------
   // Trim registers
   // ----------------------------------------
   // Reset clears them; the factory values land one cycle after release
   trim_reg #(
      .WIDTH(8),
      .RESET_VALUE(`TRIM_RST)
   ) u_gain_a (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(fuse_load),
      .load_value_in(fuse_trims_in.gain_a),
      .we_in(reg_bus_in.wr && (reg_bus_in.addr == `GAIN_A_OFS)), // R08
      .wdata_in(reg_bus_in.wdata),
      .value_out(trims_out.gain_a)
   );

   trim_reg #(
      .WIDTH(8),
      .RESET_VALUE(`TRIM_RST)
   ) u_gain_b (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(fuse_load),
      .load_value_in(fuse_trims_in.gain_b),
      .we_in(reg_bus_in.wr && (reg_bus_in.addr == `GAIN_B_OFS)), // R09
      .wdata_in(reg_bus_in.wdata),
      .value_out(trims_out.gain_b)
   );

   trim_reg #(
      .WIDTH(4),
      .RESET_VALUE(`REF_ADJ_RST)
   ) u_ref_adj (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(fuse_load),
      .load_value_in(fuse_trims_in.ref_adj),
      .we_in(reg_bus_in.wr && (reg_bus_in.addr == `REF_ADJ_OFS)), // R10
      .wdata_in(reg_bus_in.wdata[3:0]),
      .value_out(trims_out.ref_adj)
   );

   trim_reg #(
      .WIDTH(8),
      .RESET_VALUE(`TRIM_RST)
   ) u_term_a (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(fuse_load),
      .load_value_in(fuse_trims_in.term_a),
      .we_in(reg_bus_in.wr && (reg_bus_in.addr == `TERM_A_OFS)), // R11
      .wdata_in(reg_bus_in.wdata),
      .value_out(trims_out.term_a)
   );

   trim_reg #(
      .WIDTH(8),
      .RESET_VALUE(`TRIM_RST)
   ) u_term_b (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_in(fuse_load),
      .load_value_in(fuse_trims_in.term_b),
      .we_in(reg_bus_in.wr && (reg_bus_in.addr == `TERM_B_OFS)), // R12
      .wdata_in(reg_bus_in.wdata),
      .value_out(trims_out.term_b)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.fuse_done = 1'b1;
      state_next.rdata = '0;

      if (en_write) begin
         state_next.cal_en = reg_bus_in.wdata;
      end
      if (en_rise) begin
         state_next.idx = '0; // R14
      end
      // Leaving the port mid-sequence abandons a partial vector
      if (en_fall && (state_reg.idx != '0)) begin
         state_next.valid = 1'b0; // R07
      end

      if (port_ok) begin
         if (state_reg.idx == LAST_IDX) begin
            state_next.idx = '0; // R02
            state_next.valid = 1'b1; // R02
         end else begin
            state_next.idx = state_reg.idx + vec_idx_t'(1); // R14
            state_next.valid = 1'b0; // R07
         end
      end
      // Access while the engine runs is treated as corruption
      if (port_bad) begin
         state_next.valid = 1'b0;
      end

      // Read data, unmapped addresses answer zero
      if (reg_bus_in.rd) begin
         if (reg_bus_in.addr == `CAL_EN_OFS) begin
            state_next.rdata = state_reg.cal_en;
         end else if (reg_bus_in.addr == `CAL_PORT_OFS) begin
            state_next.rdata = port_ok ? host_rdata : `CAL_PORT_RST; // R01
         end else if (reg_bus_in.addr == `CAL_STATUS_OFS) begin
            state_next.rdata = status_byte;
         end else if (reg_bus_in.addr == `GAIN_A_OFS) begin
            state_next.rdata = trims_out.gain_a; // R08
         end else if (reg_bus_in.addr == `GAIN_B_OFS) begin
            state_next.rdata = trims_out.gain_b; // R09
         end else if (reg_bus_in.addr == `REF_ADJ_OFS) begin
            state_next.rdata = {4'h0, trims_out.ref_adj}; // R10
         end else if (reg_bus_in.addr == `TERM_A_OFS) begin
            state_next.rdata = trims_out.term_a; // R11
         end else if (reg_bus_in.addr == `TERM_B_OFS) begin
            state_next.rdata = trims_out.term_b; // R12
         end else begin
            state_next.rdata = '0;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Vector counts as valid at reset: the engine owns it until a host sequence
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg.rdata <= '0;
         state_reg.cal_en <= `CAL_EN_RST;
         state_reg.idx <= '0;
         state_reg.valid <= 1'b1;
         state_reg.fuse_done <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_out = state_reg.rdata;
   assign cal_port_enable_out = state_reg.cal_en[`CAL_EN_BIT];
   assign vector_valid_out = state_reg.valid;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   property p_idx_clear;
      en_rise |=> state_reg.idx == '0;
   endproperty
   a_idx_clear: assert property (p_idx_clear) else $error("index not cleared on enable"); // R14

   property p_idx_step;
      port_ok && (state_reg.idx != LAST_IDX) |=> state_reg.idx == $past(state_reg.idx) + 10'h001;
   endproperty
   a_idx_step: assert property (p_idx_step) else $error("index did not step"); // R14

   property p_wrap_valid;
      port_ok && (state_reg.idx == LAST_IDX) |=> (state_reg.idx == '0) && vector_valid_out;
   endproperty
   a_wrap_valid: assert property (p_wrap_valid) else $error("full sequence not completed"); // R02

   property p_partial_invalid;
      port_ok && (state_reg.idx != LAST_IDX) |=> !vector_valid_out;
   endproperty
   a_partial_invalid: assert property (p_partial_invalid) else $error("partial vector valid"); // R07

   property p_abort_invalid;
      en_fall && (state_reg.idx != '0) |=> !vector_valid_out && !cal_port_enable_out;
   endproperty
   a_abort_invalid: assert property (p_abort_invalid) else $error("abort left vector valid"); // R07

   property p_disabled_ignored;
      port_hit && !cal_port_enable_out |=> $stable(state_reg.idx) && (rdata_out == 8'h00);
   endproperty
   a_disabled_ignored: assert property (p_disabled_ignored) else $error("port live while off"); // R13

   property p_port_read;
      port_ok && reg_bus_in.rd |=> rdata_out == $past(host_rdata);
   endproperty
   a_port_read: assert property (p_port_read) else $error("wrong vector byte read"); // R01

   property p_gain_a_read;
      reg_bus_in.rd && (reg_bus_in.addr == `GAIN_A_OFS) |=> rdata_out == $past(trims_out.gain_a);
   endproperty
   a_gain_a_read: assert property (p_gain_a_read) else $error("gain A read mismatch"); // R08

   property p_gain_b_write;
      reg_bus_in.wr && (reg_bus_in.addr == `GAIN_B_OFS) && !fuse_load
         |=> trims_out.gain_b == $past(reg_bus_in.wdata);
   endproperty
   a_gain_b_write: assert property (p_gain_b_write) else $error("gain B not written"); // R09

   property p_ref_reserved;
      reg_bus_in.rd && (reg_bus_in.addr == `REF_ADJ_OFS)
         |=> (rdata_out[7:4] == 4'h0) && (rdata_out[3:0] == $past(trims_out.ref_adj));
   endproperty
   a_ref_reserved: assert property (p_ref_reserved) else $error("reference read wrong"); // R10

   property p_term_a_write;
      reg_bus_in.wr && (reg_bus_in.addr == `TERM_A_OFS) && !fuse_load
         |=> trims_out.term_a == $past(reg_bus_in.wdata);
   endproperty
   a_term_a_write: assert property (p_term_a_write) else $error("term A not written"); // R11

   property p_term_b_write;
      reg_bus_in.wr && (reg_bus_in.addr == `TERM_B_OFS) && !fuse_load
         |=> trims_out.term_b == $past(reg_bus_in.wdata);
   endproperty
   a_term_b_write: assert property (p_term_b_write) else $error("term B not written"); // R12

   property p_fuse_load;
      fuse_load |=> (trims_out.gain_a == $past(fuse_trims_in.gain_a)) && !fuse_load;
   endproperty
   a_fuse_load: assert property (p_fuse_load) else $error("factory trim not loaded"); // R08

   // Dropped access must leave the index untouched, read back zero and clear the valid flag
   property p_bad_access;
      port_bad |=> !vector_valid_out && $stable(state_reg.idx) && (rdata_out == 8'h00);
   endproperty
   a_bad_access: assert property (p_bad_access) else $error("access while running kept"); // R06

   property p_gain_a_write;
      reg_bus_in.wr && (reg_bus_in.addr == `GAIN_A_OFS) && !fuse_load
         |=> trims_out.gain_a == $past(reg_bus_in.wdata);
   endproperty
   a_gain_a_write: assert property (p_gain_a_write) else $error("gain A not written"); // R08

   property p_gain_b_read;
      reg_bus_in.rd && (reg_bus_in.addr == `GAIN_B_OFS) |=> rdata_out == $past(trims_out.gain_b);
   endproperty
   a_gain_b_read: assert property (p_gain_b_read) else $error("gain B read mismatch"); // R09

   property p_ref_write;
      reg_bus_in.wr && (reg_bus_in.addr == `REF_ADJ_OFS) && !fuse_load
         |=> trims_out.ref_adj == $past(reg_bus_in.wdata[3:0]);
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("reference not written"); // R10

   property p_term_b_read;
      reg_bus_in.rd && (reg_bus_in.addr == `TERM_B_OFS) |=> rdata_out == $past(trims_out.term_b);
   endproperty
   a_term_b_read: assert property (p_term_b_read) else $error("term B read mismatch"); // R12

   c_full_sequence: cover property (port_ok && (state_reg.idx == LAST_IDX));
   c_abort: cover property (en_fall && (state_reg.idx != '0));
   c_bad_access: cover property (port_bad);
   c_trim_write: cover property (reg_bus_in.wr && (reg_bus_in.addr == `TERM_B_OFS));

endmodule // cal_vector_and_trim_regs

`default_nettype wire

/* File: sim/cal_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cal_engine_model
   import cal_trim_pkg::*;
#(
   parameter int VEC_LEN = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Bench control
   input wire logic halt_req_in,
   input wire logic scan_in,
   // Block side
   output logic halted_out,
   output vec_idx_t idx_out
);

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         halted_out <= 1'b0;
         idx_out <= '0;
      end else begin
         // Stops a cycle after the request, so the host must wait for it
         halted_out <= halt_req_in;
         if (!scan_in || idx_out == vec_idx_t'(VEC_LEN - 1)) begin
            idx_out <= '0;
         end else begin
            idx_out <= idx_out + 10'h001;
         end
      end
   end

endmodule // cal_engine_model

`default_nettype wire

/* File: sim/cal_vector_and_trim_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cal_trim_map.svh"

module cal_vector_and_trim_regs_tb;
   import cal_trim_pkg::*;

   // Short vector keeps the run brief
   localparam int VEC_LEN = 8;
   localparam bus_req_s idle_req = '{addr: 12'h000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
   localparam trim_set_s fuse = '{gain_a: 8'h5a, gain_b: 8'ha5, ref_adj: 4'h9,
                                  term_a: 8'h3c, term_b: 8'hc3};
   localparam byte_t fuse_b [5] = '{8'h5a, 8'ha5, 8'h09, 8'h3c, 8'hc3};
   localparam reg_addr_t trim_addr [5] = '{`GAIN_A_OFS, `GAIN_B_OFS, `REF_ADJ_OFS,
                                          `TERM_A_OFS, `TERM_B_OFS};

   logic ref_clk_in;
   logic reset_n_in;
   bus_req_s reg_bus_in;
   byte_t rdata_out;
   logic halt_req;
   logic scan;
   logic halted;
   vec_idx_t eng_idx;
   byte_t eng_data_out;
   logic cal_port_enable_out;
   logic vector_valid_out;
   trim_set_s trims_out;
   byte_t vals [VEC_LEN];
   byte_t got;
   byte_t wd;
   vec_idx_t last;
   int n_errors;
   int total_checks;

   cal_vector_and_trim_regs #(.VEC_LEN(VEC_LEN)) cal_vector_and_trim_regs_inst (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .reg_bus_in(reg_bus_in),
      .rdata_out(rdata_out),
      .fuse_trims_in(fuse),
      .calibration_halted_in(halted),
      .eng_idx_in(eng_idx),
      .eng_data_out(eng_data_out),
      .cal_port_enable_out(cal_port_enable_out),
      .vector_valid_out(vector_valid_out),
      .trims_out(trims_out)
   );

   cal_engine_model #(.VEC_LEN(VEC_LEN)) cal_engine_model_inst (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .halt_req_in(halt_req),
      .scan_in(scan),
      .halted_out(halted),
      .idx_out(eng_idx)
   );

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic wrap_up();
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp8(input byte_t act, input byte_t exp);
      total_checks++;
      if (act !== exp) begin
         n_errors++;
         $display("mismatch at %0t: byte %h, expected %h", $time, act, exp);
      end
   endtask

   task automatic cmp1(input logic act, input logic exp);
      total_checks++;
      if (act !== exp) begin
         n_errors++;
         $display("mismatch at %0t: flag %b, expected %b", $time, act, exp);
      end
   endtask

   // Leaves the request up so writes can follow back to back
   task automatic wr(input reg_addr_t a, input byte_t d);
      reg_bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
   endtask

   task automatic idle();
      reg_bus_in <= idle_req;
      @(posedge ref_clk_in);
   endtask

   task automatic rd_cmp(input reg_addr_t a, input byte_t exp);
      reg_bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      reg_bus_in <= idle_req;
      #1;
      got = rdata_out;
      cmp8(got, exp);
      @(posedge ref_clk_in);
   endtask

   task automatic read_vec(input int n);
      for (int i = 0; i < n; i++) begin
         rd_cmp(`CAL_PORT_OFS, vals[i]);
      end
   endtask

   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end

   initial begin
      #(50 * 4000);
      n_errors++;
      $display("mismatch at %0t: run did not finish in time", $time);
      wrap_up();
   end

   initial begin
      reset_n_in = 1'b0;
      reg_bus_in = idle_req;
      halt_req = 1'b1;
      scan = 1'b0;
      n_errors = 0;
      total_checks = 0;
      for (int i = 0; i < VEC_LEN; i++) begin
         vals[i] = byte_t'(i * 37 + 59);
      end
      repeat (2) @(posedge ref_clk_in);
      cmp8(trims_out.gain_a, 8'h00);
      cmp8(trims_out.term_b, 8'h00);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      cmp8(trims_out.term_a, fuse.term_a);
      for (int i = 0; i < 5; i++) begin
         rd_cmp(trim_addr[i], fuse_b[i]);
      end
      for (int i = 0; i < 5; i++) begin
         wr(trim_addr[i], ~fuse_b[i]);
      end
      wr(12'h07d, 8'h77);
      idle();
      cmp8(trims_out.gain_b, ~fuse.gain_b);
      cmp8({4'h0, trims_out.ref_adj}, {4'h0, ~fuse.ref_adj});
      rd_cmp(12'h07d, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wd = ~fuse_b[i];
         rd_cmp(trim_addr[i], (i == 2) ? {4'h0, wd[3:0]} : wd);
      end
      // Port closed: read gives 0 and leaves the index alone
      rd_cmp(`CAL_PORT_OFS, 8'h00);
      cmp1(vector_valid_out, 1'b1);
      wr(`CAL_EN_OFS, 8'h01);
      for (int i = 0; i < 3; i++) begin
         wr(`CAL_PORT_OFS, vals[i]);
      end
      idle();
      cmp1(vector_valid_out, 1'b0);
      cmp1(cal_port_enable_out, 1'b1);
      for (int i = 3; i < VEC_LEN; i++) begin
         wr(`CAL_PORT_OFS, vals[i]);
      end
      idle();
      cmp1(vector_valid_out, 1'b1);
      scan <= 1'b1;
      for (int i = 0; i < VEC_LEN + 2; i++) begin
         last = eng_idx;
         @(posedge ref_clk_in);
         #1;
         cmp8(eng_data_out, vals[last]);
      end
      @(posedge ref_clk_in);
      scan <= 1'b0;
      wr(`CAL_EN_OFS, 8'h00);
      wr(`CAL_EN_OFS, 8'h01);
      idle();
      cmp1(vector_valid_out, 1'b1);
      read_vec(VEC_LEN);
      cmp1(vector_valid_out, 1'b1);
      rd_cmp(`CAL_STATUS_OFS, 8'h07);
      rd_cmp(`CAL_EN_OFS, 8'h01);
      // Engine running: access dropped, vector flagged bad
      halt_req <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rd_cmp(`CAL_PORT_OFS, 8'h00);
      wr(`CAL_PORT_OFS, 8'hee);
      idle();
      cmp1(vector_valid_out, 1'b0);
      halt_req <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      read_vec(VEC_LEN);
      cmp1(vector_valid_out, 1'b1);
      // Readout abandoned part way
      wr(`CAL_EN_OFS, 8'h00);
      wr(`CAL_EN_OFS, 8'h01);
      idle();
      read_vec(3);
      wr(`CAL_EN_OFS, 8'h00);
      idle();
      cmp1(vector_valid_out, 1'b0);
      cmp1(cal_port_enable_out, 1'b0);
      wrap_up();
   end

endmodule // cal_vector_and_trim_regs_tb

`default_nettype wire
